// ===== pkg/emt_pkg.sv
/*
 package for the execution mode and timing controller: operation classes,
 operand forms, modes, states, cycle counts and the packed carriers.
 assumes a single core clock and an upstream decoder that classifies ops.
*/
package emt_pkg;

   localparam logic [1:0] REFILL_MIN    = 2'h1;
   localparam logic [1:0] REFILL_MAX    = 2'h3;
   localparam logic [7:0] SINGLE_CYCLES = 8'h01;
   localparam logic [7:0] BARRIER_MIN   = 8'h00;
   localparam int         LIST_W        = 16;

   typedef enum logic [1:0] {
      EMT_MODE_THREAD,
      EMT_MODE_HANDLER
   } emt_mode_t;

   typedef enum logic [1:0] {
      EMT_ST_NORMAL,
      EMT_ST_DEBUG
   } emt_state_t;

   typedef enum logic [3:0] {
      EMT_OP_MOVE_REG,
      EMT_OP_MOVE_WIDE_IMMEDIATE,
      EMT_OP_MOVE_TOP_IMMEDIATE,
      EMT_OP_ADD,
      EMT_OP_ADD_CARRY,
      EMT_OP_FORM_ADDRESS,
      EMT_OP_SUBTRACT,
      EMT_OP_SUBTRACT_WITH_BORROW_OP,
      EMT_OP_REVERSE_SUBTRACT_OP,
      EMT_OP_MULTIPLY_OP,
      EMT_OP_PC_WRITE,
      EMT_OP_DATA_MEMORY_BARRIER,
      EMT_OP_DATA_SYNC_BARRIER,
      EMT_OP_INSTRUCTION_SYNC_BARRIER,
      EMT_OP_MULTI_XFER,
      EMT_OP_WAIT_EVENT
   } emt_op_t;

   typedef enum logic [1:0] {
      EMT_OPND_REG,
      EMT_OPND_REG_SHIFT_IMM,
      EMT_OPND_REG_SHIFT_REG,
      EMT_OPND_IMM
   } emt_opnd_t;

   // one issued instruction from the decoder
   typedef struct packed {
      logic              valid;
      emt_op_t           op;
      emt_opnd_t         opnd;
      logic              wide;        // 32-bit encoding
      logic [31:0]       pc;
      logic [31:0]       target;      // branch target for pc writes
      logic              spec_hit;    // target speculated early
      logic [LIST_W-1:0] reg_list;    // includes pc and lr bits
      logic              barrier_busy;
   } emt_issue_t;

   // mode, privilege and state seen by the rest of the core
   typedef struct packed {
      emt_mode_t  mode;
      logic       privileged;
      emt_state_t state;
      logic       align_fault;
      logic       opnd_ok;
   } emt_status_t;

endpackage

// ===== verilog/emt_refill.sv
/*
 emt_refill: pipeline refill cost from target alignment, width and
 whether the fetch unit speculated the target early.
 assumes target and wide are stable while start is asserted.
*/
`timescale 1ns/1ps
module emt_refill (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // request
   input  wire logic        start,
   input  wire logic [31:0] target,
   input  wire logic        wide,
   input  wire logic        spec_hit,
   // result
   output logic [1:0]       cost
);

   typedef struct packed {
      logic [1:0] cost;
   } emt_refill_state_t;

   emt_refill_state_t cur_ff;
   emt_refill_state_t nxt_cur;

   always_comb begin
      nxt_cur = cur_ff;
      if (start) begin
         // speculated targets are already on the way: cheapest refill
         if (spec_hit)
            nxt_cur.cost = emt_pkg::REFILL_MIN;
         else if (wide && target[1])
            // a wide op straddling words needs a second fetch
            nxt_cur.cost = emt_pkg::REFILL_MAX;
         else
            nxt_cur.cost = emt_pkg::REFILL_MIN + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         cur_ff <= '{cost: emt_pkg::REFILL_MIN};
      else
         cur_ff <= nxt_cur;
   end

   assign cost = cur_ff.cost;

endmodule // emt_refill

// ===== verilog/emt_core_ctrl.sv
/*
 emt_core_ctrl: operating mode, privilege, execution state and the
 cycle cost sequencer for each issued instruction.
 assumes one issue at a time, taken only while issue_ready is high, and
 mem_wait from the memory system high for each stalled cycle.
*/
`timescale 1ns/1ps
module emt_core_ctrl #(
   parameter int LIST_W = emt_pkg::LIST_W
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rstn,
   // issue from decoder
   input  wire emt_pkg::emt_issue_t issue,
   // exception and debug control
   input  wire logic               exc_take,
   input  wire logic               exc_return,
   input  wire logic               set_unpriv,
   input  wire logic               halt_req,
   input  wire logic               resume_req,
   // memory and event
   input  wire logic               mem_wait,
   input  wire logic               event_seen,
   // outputs
   output logic                    issue_ready,
   output logic                    retire,
   output logic [7:0]              last_cycles,
   output emt_pkg::emt_status_t    status
);

   typedef enum {
      SEQ_IDLE,
      SEQ_EXEC,
      SEQ_REFILL,
      SEQ_WAIT_EVENT
   } emt_seq_t;

   typedef struct packed {
      emt_pkg::emt_status_t status;
      logic                 thread_priv;
      emt_seq_t             seq;
      logic [7:0]           remain;
      logic [7:0]           count;
      logic [7:0]           last_cycles;
      logic                 retire;
      logic                 ready;
      logic                 isb_pend;
   } emt_ctrl_state_t;

   emt_ctrl_state_t cur_ff;
   emt_ctrl_state_t nxt_cur;
   logic [1:0]      refill_cost;
   logic            refill_start;

   function automatic logic [7:0] list_count(input logic [LIST_W-1:0] l);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 0; i < LIST_W; i++)
         n = n + {7'h00, l[i]};
      return n;
   endfunction

   // saturating: a very long event wait reads back as 255
   function automatic logic [7:0] inc_sat(input logic [7:0] v);
      return (v == 8'hFF) ? v : v + 8'h01;
   endfunction

   // fixed-operand ops take one form only; ops that accept the
   // flexible second operand take all four
   function automatic logic opnd_legal(input emt_pkg::emt_op_t   op,
                                       input emt_pkg::emt_opnd_t f);
      case (op)
         emt_pkg::EMT_OP_MOVE_WIDE_IMMEDIATE,
         emt_pkg::EMT_OP_MOVE_TOP_IMMEDIATE,
         emt_pkg::EMT_OP_FORM_ADDRESS:
            return f == emt_pkg::EMT_OPND_IMM;
         emt_pkg::EMT_OP_MULTIPLY_OP,
         emt_pkg::EMT_OP_PC_WRITE:
            return f == emt_pkg::EMT_OPND_REG;
         default:
            return 1'b1;
      endcase
   endfunction

   // refill cost is worked out once, at the edge that takes the op
   assign refill_start = issue.valid && cur_ff.ready &&
                         (issue.op == emt_pkg::EMT_OP_PC_WRITE ||
                          issue.op == emt_pkg::EMT_OP_INSTRUCTION_SYNC_BARRIER);

   emt_refill u_refill (
      .core_clk (core_clk),
      .rstn     (rstn),
      .start    (refill_start),
      .target   (issue.target),
      .wide     (issue.wide),
      .spec_hit (issue.spec_hit),
      .cost     (refill_cost)
   );

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.retire = 1'b0;

      // mode and privilege
      if (exc_take) begin
         nxt_cur.status.mode = emt_pkg::EMT_MODE_HANDLER;
      end else if (exc_return) begin
         nxt_cur.status.mode = emt_pkg::EMT_MODE_THREAD;
      end
      if (set_unpriv)
         nxt_cur.thread_priv = 1'b0;
      nxt_cur.status.privileged =
         (nxt_cur.status.mode == emt_pkg::EMT_MODE_HANDLER) ||
         nxt_cur.thread_priv;

      // halting debug: an op in flight still runs on to retire, nothing new is taken
      if (halt_req)
         nxt_cur.status.state = emt_pkg::EMT_ST_DEBUG;
      else if (resume_req)
         nxt_cur.status.state = emt_pkg::EMT_ST_NORMAL;

      case (cur_ff.seq)
         SEQ_IDLE: begin
            if (issue.valid && cur_ff.ready) begin
               // halfword alignment only; wide ops may straddle words
               nxt_cur.status.align_fault = issue.pc[0];
               nxt_cur.status.opnd_ok =
                  opnd_legal(issue.op, issue.opnd);
               nxt_cur.count = 8'h00;
               nxt_cur.isb_pend = 1'b0;
               case (issue.op)
                  emt_pkg::EMT_OP_PC_WRITE: begin
                     nxt_cur.remain = emt_pkg::SINGLE_CYCLES;
                     nxt_cur.isb_pend = 1'b1;
                  end
                  // barrier_busy is not looked at: barriers take the minimum
                  emt_pkg::EMT_OP_DATA_MEMORY_BARRIER,
                  emt_pkg::EMT_OP_DATA_SYNC_BARRIER:
                     nxt_cur.remain = emt_pkg::BARRIER_MIN;
                  emt_pkg::EMT_OP_INSTRUCTION_SYNC_BARRIER: begin
                     nxt_cur.remain = emt_pkg::BARRIER_MIN;
                     nxt_cur.isb_pend = 1'b1;
                  end
                  emt_pkg::EMT_OP_MULTI_XFER:
                     nxt_cur.remain = list_count(issue.reg_list);
                  emt_pkg::EMT_OP_WAIT_EVENT:
                     nxt_cur.remain = emt_pkg::SINGLE_CYCLES;
                  default:
                     nxt_cur.remain = emt_pkg::SINGLE_CYCLES;
               endcase
               nxt_cur.seq = (issue.op == emt_pkg::EMT_OP_WAIT_EVENT) ?
                             SEQ_WAIT_EVENT : SEQ_EXEC;
               nxt_cur.ready = 1'b0;
            end
         end
         SEQ_WAIT_EVENT: begin
            nxt_cur.count = inc_sat(cur_ff.count);
            if (event_seen)
               nxt_cur.seq = SEQ_EXEC;
         end
         SEQ_EXEC: begin
            if (mem_wait) begin
               // a stalled cycle leaves remain alone but still counts
               nxt_cur.count = inc_sat(cur_ff.count);
            end else if (cur_ff.remain != 8'h00) begin
               nxt_cur.remain = cur_ff.remain - 8'h01;
               nxt_cur.count = inc_sat(cur_ff.count);
            end else if (cur_ff.isb_pend) begin
               // cost was latched at the taking edge, one edge earlier for isb, two for pc writes
               nxt_cur.remain = {6'h00, refill_cost};
               nxt_cur.isb_pend = 1'b0;
               nxt_cur.seq = SEQ_REFILL;
            end else begin
               nxt_cur.last_cycles = cur_ff.count;
               nxt_cur.retire = 1'b1;
               nxt_cur.ready = 1'b1;
               nxt_cur.seq = SEQ_IDLE;
            end
         end
         SEQ_REFILL: begin
            if (mem_wait) begin
               nxt_cur.count = inc_sat(cur_ff.count);
            end else if (cur_ff.remain != 8'h00) begin
               nxt_cur.remain = cur_ff.remain - 8'h01;
               nxt_cur.count = inc_sat(cur_ff.count);
            end else begin
               nxt_cur.last_cycles = cur_ff.count;
               nxt_cur.retire = 1'b1;
               nxt_cur.ready = 1'b1;
               nxt_cur.seq = SEQ_IDLE;
            end
         end
         default: nxt_cur.seq = SEQ_IDLE;
      endcase

      // debug state holds off new issue
      if (nxt_cur.status.state == emt_pkg::EMT_ST_DEBUG)
         nxt_cur.ready = 1'b0;
      else if (nxt_cur.seq == SEQ_IDLE)
         nxt_cur.ready = 1'b1;
   end

   // reset leaves a privileged thread in normal state, ready to issue
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cur_ff <= '0;
         cur_ff.status.mode <= emt_pkg::EMT_MODE_THREAD;
         cur_ff.status.privileged <= 1'b1;
         cur_ff.status.state <= emt_pkg::EMT_ST_NORMAL;
         cur_ff.thread_priv <= 1'b1;
         cur_ff.seq <= SEQ_IDLE;
         cur_ff.ready <= 1'b1;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign issue_ready = cur_ff.ready;
   assign retire      = cur_ff.retire;
   assign last_cycles = cur_ff.last_cycles;
   assign status      = cur_ff.status;

endmodule // emt_core_ctrl

// ===== tb/emt_core_ctrl_properties.sv
/*
 emt_core_ctrl_properties: port checks of mode, state and issue costs.
 assumes it is bound onto emt_core_ctrl and sees its ports only.
*/
`timescale 1ns/1ps
module emt_core_ctrl_properties #(
   parameter int LIST_W = emt_pkg::LIST_W
) (
   // clock and reset
   input wire logic                 core_clk,
   input wire logic                 rstn,
   // design inputs
   input wire emt_pkg::emt_issue_t  issue,
   input wire logic                 exc_take,
   input wire logic                 exc_return,
   input wire logic                 set_unpriv,
   input wire logic                 halt_req,
   input wire logic                 resume_req,
   input wire logic                 mem_wait,
   input wire logic                 event_seen,
   // design outputs
   input wire logic                 issue_ready,
   input wire logic                 retire,
   input wire logic [7:0]           last_cycles,
   input wire emt_pkg::emt_status_t status
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_taken;
      issue.valid && issue_ready;
   endsequence
   sequence s_simple;
      s_taken ##0 (issue.op <= emt_pkg::EMT_OP_MULTIPLY_OP) && !mem_wait;
   endsequence
   sequence s_pc_write;
      s_taken ##0 issue.op == emt_pkg::EMT_OP_PC_WRITE && !mem_wait;
   endsequence
   sequence s_barrier;
      s_taken ##0 (issue.op == emt_pkg::EMT_OP_DATA_MEMORY_BARRIER ||
                   issue.op == emt_pkg::EMT_OP_DATA_SYNC_BARRIER);
   endsequence

   a_reset_thread: assert property ($rose(rstn) |->
      status.mode == emt_pkg::EMT_MODE_THREAD && status.privileged)
      else $error("not privileged thread after reset");
   a_exc_handler: assert property (exc_take |=>
      status.mode == emt_pkg::EMT_MODE_HANDLER)
      else $error("exception did not enter handler mode");
   a_exc_return: assert property (exc_return && !exc_take |=>
      status.mode == emt_pkg::EMT_MODE_THREAD)
      else $error("exception return did not enter thread mode");
   a_handler_priv: assert property (
      status.mode == emt_pkg::EMT_MODE_HANDLER |-> status.privileged)
      else $error("handler mode without privilege");
   a_halt_debug: assert property (halt_req |=>
      status.state == emt_pkg::EMT_ST_DEBUG)
      else $error("halt did not enter debug state");
   a_resume_normal: assert property (resume_req && !halt_req |=>
      status.state == emt_pkg::EMT_ST_NORMAL)
      else $error("resume did not leave debug state");
   a_debug_refuses: assert property (status.state == emt_pkg::EMT_ST_DEBUG &&
      $past(status.state) == emt_pkg::EMT_ST_DEBUG |-> !issue_ready)
      else $error("issue accepted in debug state");
   a_single_cycle: assert property (s_simple |-> ##[2:8] retire)
      else $error("simple op did not retire");
   a_barrier_zero: assert property (s_barrier |->
      ##[2:8] (retire && last_cycles == 8'h00))
      else $error("barrier count not zero");
   a_pc_write_cost: assert property (s_pc_write |->
      ##[3:8] (retire && last_cycles >= 8'h02 && last_cycles <= 8'h04))
      else $error("pc write cost outside one plus refill");
endmodule // emt_core_ctrl_properties

// ===== tb/emt_core_ctrl_tb.sv
/*
 emt_core_ctrl_tb: self-checking bench for modes, states and op costs.
 assumes emt_pkg is compiled first; the bench drives every port.
*/
`timescale 1ns/1ps
module emt_core_ctrl_tb;
   logic                 core_clk = 1'b0;
   logic                 rstn = 1'b0;
   emt_pkg::emt_issue_t  issue = '0;
   emt_pkg::emt_issue_t  cur = '0;
   logic [4:0]           ctl = 5'h00;
   logic                 mem_wait = 1'b0;
   logic                 event_seen = 1'b0;
   logic                 issue_ready;
   logic                 retire;
   logic [7:0]           last_cycles;
   emt_pkg::emt_status_t status;
   logic [127:0]         r;
   int                   mismatches = 0;
   int                   check_count = 0;
   int                   seed = 74352;

   always #2.5 core_clk = ~core_clk;

   emt_core_ctrl emt_core_ctrl_inst (
      .core_clk(core_clk), .rstn(rstn), .issue(issue),
      .exc_take(ctl[4]), .exc_return(ctl[3]), .set_unpriv(ctl[2]),
      .halt_req(ctl[1]), .resume_req(ctl[0]), .mem_wait(mem_wait),
      .event_seen(event_seen), .issue_ready(issue_ready),
      .retire(retire), .last_cycles(last_cycles), .status(status));

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic st(input string nm, input logic [1:0] m, input logic p);
      chk(nm, {5'h0, m, p}, {5'h0, status.mode, status.privileged});
   endtask

   task automatic pulse(input logic [4:0] v);
      @(posedge core_clk) ctl <= v;
      @(posedge core_clk) ctl <= 5'h00;
      repeat (2) @(negedge core_clk);
   endtask

   task automatic do_reset();
      @(posedge core_clk) rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      @(negedge core_clk);
      st("reset_mode", emt_pkg::EMT_MODE_THREAD, 1'b1);
      chk("reset_out", 8'h02, {6'h0, issue_ready, retire});
      chk("reset_cycles", 8'h00, last_cycles);
   endtask

   // refill cost follows target width, alignment and early speculation
   function automatic logic [7:0] refill(emt_pkg::emt_issue_t i);
      if (i.spec_hit) return 8'h01;
      if (i.wide && i.target[1]) return 8'h03;
      return 8'h02;
   endfunction

   // fixed-operand ops take one form; flexible ones take all four
   function automatic logic [7:0] opnd_exp(emt_pkg::emt_issue_t i);
      case (i.op)
         emt_pkg::EMT_OP_MOVE_WIDE_IMMEDIATE,
         emt_pkg::EMT_OP_MOVE_TOP_IMMEDIATE,
         emt_pkg::EMT_OP_FORM_ADDRESS:
            return {7'h0, i.opnd == emt_pkg::EMT_OPND_IMM};
         emt_pkg::EMT_OP_MULTIPLY_OP,
         emt_pkg::EMT_OP_PC_WRITE:
            return {7'h0, i.opnd == emt_pkg::EMT_OPND_REG};
         default: return 8'h01;
      endcase
   endfunction

   function automatic logic [7:0] expect_cyc(emt_pkg::emt_issue_t i);
      case (i.op)
         emt_pkg::EMT_OP_PC_WRITE: return 8'h01 + refill(i);
         emt_pkg::EMT_OP_INSTRUCTION_SYNC_BARRIER: return refill(i);
         emt_pkg::EMT_OP_DATA_MEMORY_BARRIER: return 8'h00;
         emt_pkg::EMT_OP_DATA_SYNC_BARRIER: return 8'h00;
         emt_pkg::EMT_OP_MULTI_XFER: return 8'($countones(i.reg_list));
         default: return 8'h01;
      endcase
   endfunction

   // valid held to the taking edge only; bounded waits on both sides
   task automatic run_op();
      int n;
      for (n = 0; n < 300 && issue_ready !== 1'b1; n++) @(negedge core_clk);
      if (issue_ready !== 1'b1) begin
         mismatches++;
         $display("Error issue_ready expected 1 seen %0b", issue_ready);
         close_out();
      end
      cur.valid = 1'b1;
      @(posedge core_clk) issue <= cur;
      @(posedge core_clk) issue.valid <= 1'b0;
      @(negedge core_clk);
      for (n = 0; n < 300 && retire !== 1'b1; n++) @(negedge core_clk);
      if (retire !== 1'b1) begin
         mismatches++;
         $display("Error retire expected 1 seen 0");
         close_out();
      end
   endtask

   initial begin
      int j;
      do_reset();
      pulse(5'h10);
      st("exc_take", emt_pkg::EMT_MODE_HANDLER, 1'b1);
      pulse(5'h04);
      st("handler_priv", emt_pkg::EMT_MODE_HANDLER, 1'b1);
      pulse(5'h08);
      st("exc_ret", emt_pkg::EMT_MODE_THREAD, 1'b0);
      pulse(5'h18);
      st("take_wins", emt_pkg::EMT_MODE_HANDLER, 1'b1);
      pulse(5'h08);
      $display("test modes done");
      pulse(5'h03);
      chk("halt", 8'(emt_pkg::EMT_ST_DEBUG), 8'(status.state));
      cur.valid = 1'b1;
      @(posedge core_clk) issue <= cur;
      repeat (4) begin
         @(negedge core_clk);
         chk("refused", 8'h00, {6'h0, issue_ready, retire});
      end
      @(posedge core_clk) issue.valid <= 1'b0;
      pulse(5'h01);
      chk("resume", 8'(emt_pkg::EMT_ST_NORMAL), 8'(status.state));
      $display("test debug done");
      for (int k = 0; k < 76; k++) begin
         r = {$random(seed), $random(seed), $random(seed), $random(seed)};
         cur = r[89:0];
         j = (k < 15) ? k : int'(r[127:100] % 15);
         cur.op = emt_pkg::emt_op_t'(j[3:0]);
         if (k >= 60) begin
            cur.op = k[3] ? emt_pkg::EMT_OP_INSTRUCTION_SYNC_BARRIER
                          : emt_pkg::EMT_OP_PC_WRITE;
            {cur.spec_hit, cur.wide, cur.target[1]} = k[2:0];
         end
         if (k == 14) cur.reg_list = 16'hFFFF;
         run_op();
         chk("cycles", expect_cyc(cur), last_cycles);
         chk("align", {7'h0, cur.pc[0]}, {7'h0, status.align_fault});
         chk("opnd", opnd_exp(cur), {7'h0, status.opnd_ok});
      end
      $display("test costs done");
      cur.op = emt_pkg::EMT_OP_MOVE_REG;
      fork
         run_op();
         begin
            repeat (2) @(posedge core_clk);
            mem_wait <= 1'b1;
            repeat (3) @(posedge core_clk);
            mem_wait <= 1'b0;
         end
      join
      // three stalled cycles add to the single cycle of the move
      chk("mem_wait", 8'h04, last_cycles);
      cur.op = emt_pkg::EMT_OP_WAIT_EVENT;
      fork
         run_op();
         begin
            repeat (6) @(posedge core_clk);
            event_seen <= 1'b1;
         end
      join
      // five cycles spent waiting, then the single execute cycle
      chk("event_wait", 8'h06, last_cycles);
      @(posedge core_clk) event_seen <= 1'b0;
      $display("test waits done");
      pulse(5'h10);
      do_reset();
      $display("test reset done");
      close_out();
   end
endmodule // emt_core_ctrl_tb

bind emt_core_ctrl emt_core_ctrl_properties #(.LIST_W(LIST_W))
   emt_core_ctrl_properties_inst (
   .core_clk(core_clk), .rstn(rstn), .issue(issue),
   .exc_take(exc_take), .exc_return(exc_return), .set_unpriv(set_unpriv),
   .halt_req(halt_req), .resume_req(resume_req), .mem_wait(mem_wait),
   .event_seen(event_seen), .issue_ready(issue_ready), .retire(retire),
   .last_cycles(last_cycles), .status(status));
